/* src/bad_pkg.sv */
// package: constants, types and contract list for the board address decoder
// Contract
// - vme window sits right above dram
// - addresses above window alias the window
// - real-mode window e0000..effff when enabled
// - separate 64k io space, any width
// - expansion decode uses low ten lines
// - ports 140h..14fh select vme registers
// - interrupt controllers at 020h and 0a0h
// - dma at 000h, 080h, 0c0h ranges
// - interval timer at 040h..043h
// - keyboard group at 060h..064h
// - real-time clock at 070h..071h
// - gate/reset register at 092h
// - coprocessor and config at 0f0h..0ffh
// - serial ports at 3f8h and 2f8h
// - disk task registers 1f0h and 170h
// - floppy controller at 3f0h..3f7h
// - unimplemented legacy ranges get no select
// - video at 3b0h or 3d0h per setting
// - low 1k vector table, 16+1 interrupts
// - nmi carries parity/vme, gated by enable
// - vme irq on line 11, jumper 12
package bad_pkg;
  // ************************************************************
  // memory map
  // ************************************************************
  localparam logic [31:0] BAD_WIN_1M     = 32'h0010_0000; // dram fit 1
  localparam logic [31:0] BAD_WIN_4M     = 32'h0040_0000; // dram fit 4
  localparam logic [31:0] BAD_WIN_16M    = 32'h0100_0000; // dram fit 16
  localparam logic [31:0] BAD_WIN_SIZE   = 32'h0100_0000; // window span
  localparam logic [31:0] BAD_ALIAS_TOP  = 32'hFFFD_FFFF; // last alias
  localparam logic [31:0] BAD_RSVD_BASE  = 32'hFFFE_0000; // reserved
  localparam logic [31:0] BAD_ROM_BASE   = 32'hFFFF_0000; // rom image
  localparam logic [31:0] BAD_RM_LO      = 32'h000E_0000; // real window
  localparam logic [31:0] BAD_RM_HI      = 32'h000E_FFFF;
  localparam logic [31:0] BAD_RM_ROM_LO  = 32'h000F_0000; // real rom
  localparam logic [31:0] BAD_IVT_HI     = 32'h0000_03FF; // vector table
  // ************************************************************
  // port map (10-bit decode)
  // ************************************************************
  localparam logic [9:0] BAD_P_DMA1    = 10'h000;
  localparam logic [9:0] BAD_P_PIC1    = 10'h020;
  localparam logic [9:0] BAD_P_PIT     = 10'h040;
  localparam logic [9:0] BAD_P_KBD     = 10'h060;
  localparam logic [9:0] BAD_P_KBD_HI  = 10'h064;
  localparam logic [9:0] BAD_P_RTC     = 10'h070;
  localparam logic [9:0] BAD_P_PAGE    = 10'h080;
  localparam logic [9:0] BAD_P_GATE    = 10'h092;
  localparam logic [9:0] BAD_P_PIC2    = 10'h0A0;
  localparam logic [9:0] BAD_P_DMA2    = 10'h0C0;
  localparam logic [9:0] BAD_P_DMA2_HI = 10'h0DF;
  localparam logic [9:0] BAD_P_FPU     = 10'h0F0;
  localparam logic [9:0] BAD_P_VME     = 10'h140;
  localparam logic [9:0] BAD_P_HD2     = 10'h170;
  localparam logic [9:0] BAD_P_HD1     = 10'h1F0;
  localparam logic [9:0] BAD_P_SER2    = 10'h2F8;
  localparam logic [9:0] BAD_P_MONO    = 10'h3B0;
  localparam logic [9:0] BAD_P_COLR    = 10'h3D0;
  localparam logic [9:0] BAD_P_FDC     = 10'h3F0;
  localparam logic [9:0] BAD_P_SER1    = 10'h3F8;
  localparam logic [5:0] BAD_EXP_TOP   = 6'h00;   // a15..a10 must be 0
  localparam logic [7:0] BAD_GATE_RST  = 8'h00;   // gate reg reset
  localparam int         BAD_VID_SPAN  = 16;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] { BAD_FIT_1M, BAD_FIT_4M, BAD_FIT_16M }
    bad_fit_t;
  typedef enum logic [2:0] { BAD_M_NONE, BAD_M_DRAM, BAD_M_VME,
    BAD_M_ROM, BAD_M_RSVD } bad_mem_t;
  typedef enum logic [4:0] { BAD_S_NONE, BAD_S_DMA1, BAD_S_PIC1,
    BAD_S_PIT, BAD_S_KBD, BAD_S_RTC, BAD_S_PAGE, BAD_S_GATE, BAD_S_PIC2,
    BAD_S_DMA2, BAD_S_FPU, BAD_S_VME, BAD_S_HD2, BAD_S_HD1, BAD_S_SER2,
    BAD_S_VID, BAD_S_FDC, BAD_S_SER1 } bad_sel_t;
endpackage

/* src/bad_dec_if.sv */
// interface: decoded cycle from the port decoder to the top
`timescale 1ns/10ps
`default_nettype none
interface bad_dec_if;
  logic [15:0] port;  // port address lines of the cycle
  logic        mono;  // video in monochrome range
  bad_pkg::bad_sel_t sel; // decoded peripheral
  modport dec (input port, input mono, output sel);
  modport top (output port, output mono, input sel);
endinterface
`default_nettype wire

/* src/bad_port_dec.sv */
// module: combinational i/o port decoder
`timescale 1ns/10ps
`default_nettype none
module bad_port_dec
  import bad_pkg::*;
(
  bad_dec_if.dec d // decode request and result
);
  // ************************************************************
  // range helper
  // ************************************************************
  function automatic logic in_rng(input logic [9:0] a,
                                  input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  logic [9:0] a;  // low ten lines only
  logic       ok; // upper lines clear
  logic [9:0] vid; // chosen video base

  // decode chain, priority irrelevant since ranges are disjoint
  always_comb
  begin
    a = d.port[9:0];
    ok = (d.port[15:10] == BAD_EXP_TOP);
    vid = d.mono ? BAD_P_MONO : BAD_P_COLR;
    d.sel = BAD_S_NONE; // unimplemented ranges fall here
    if (!ok)
      d.sel = BAD_S_NONE;
    else if (in_rng(a, BAD_P_DMA1, BAD_P_DMA1 + 10'h00F))
      d.sel = BAD_S_DMA1;
    else if (in_rng(a, BAD_P_PIC1, BAD_P_PIC1 + 10'h001))
      d.sel = BAD_S_PIC1;
    else if (in_rng(a, BAD_P_PIT, BAD_P_PIT + 10'h003))
      d.sel = BAD_S_PIT;
    else if (in_rng(a, BAD_P_KBD, BAD_P_KBD_HI))
      d.sel = BAD_S_KBD;
    else if (in_rng(a, BAD_P_RTC, BAD_P_RTC + 10'h001))
      d.sel = BAD_S_RTC;
    else if (in_rng(a, BAD_P_PAGE, BAD_P_PAGE + 10'h00F))
      d.sel = BAD_S_PAGE;
    else if (a == BAD_P_GATE)
      d.sel = BAD_S_GATE;
    else if (in_rng(a, BAD_P_PIC2, BAD_P_PIC2 + 10'h001))
      d.sel = BAD_S_PIC2;
    else if (in_rng(a, BAD_P_DMA2, BAD_P_DMA2_HI))
      d.sel = BAD_S_DMA2;
    else if (in_rng(a, BAD_P_FPU, BAD_P_FPU + 10'h00F))
      d.sel = BAD_S_FPU;
    else if (in_rng(a, BAD_P_VME, BAD_P_VME + 10'h00F))
      d.sel = BAD_S_VME;
    else if (in_rng(a, BAD_P_HD2, BAD_P_HD2 + 10'h007))
      d.sel = BAD_S_HD2;
    else if (in_rng(a, BAD_P_HD1, BAD_P_HD1 + 10'h007))
      d.sel = BAD_S_HD1;
    else if (in_rng(a, BAD_P_SER2, BAD_P_SER2 + 10'h006))
      d.sel = BAD_S_SER2;
    else if (in_rng(a, vid, vid + 10'(BAD_VID_SPAN - 1)))
      d.sel = BAD_S_VID;
    else if (in_rng(a, BAD_P_FDC, BAD_P_FDC + 10'h007))
      d.sel = BAD_S_FDC;
    else if (in_rng(a, BAD_P_SER1, BAD_P_SER1 + 10'h006))
      d.sel = BAD_S_SER1;
  end
endmodule
`default_nettype wire

/* src/bad_mem_dec.sv */
// module: combinational memory address decoder
`timescale 1ns/10ps
`default_nettype none
module bad_mem_dec
  import bad_pkg::*;
(
  input  wire logic [31:0] addr,    // memory address
  input  wire bad_fit_t    fit,     // dram fit
  input  wire logic        real_md, // 20-bit real mode map
  input  wire logic        vme_en,  // vme access enabled
  output bad_mem_t         target,  // decoded target
  output logic [23:0]      vme_off  // offset inside window
);
  logic [31:0] base; // window base
  logic [31:0] diff; // address minus base

  // target selection; aliases fold onto the window by low 24 bits
  always_comb
  begin
    case (fit)
      BAD_FIT_4M:  base = BAD_WIN_4M;
      BAD_FIT_16M: base = BAD_WIN_16M;
      default:     base = BAD_WIN_1M;
    endcase
    diff = addr - base;
    vme_off = diff[23:0];
    target = BAD_M_NONE;
    if (real_md)
    begin
      if (addr > 32'h000F_FFFF)
        target = BAD_M_NONE;
      else if (addr >= BAD_RM_ROM_LO)
        target = BAD_M_ROM;
      else if (addr >= BAD_RM_LO && addr <= BAD_RM_HI)
        target = vme_en ? BAD_M_VME : BAD_M_NONE;
      else
        target = BAD_M_DRAM; // vector table at bottom
      vme_off = {8'h00, addr[15:0]};
    end
    else if (addr >= BAD_ROM_BASE)
      target = BAD_M_ROM;
    else if (addr >= BAD_RSVD_BASE)
      target = BAD_M_RSVD; // no vme cycle
    else if (addr >= base)
      target = vme_en ? BAD_M_VME : BAD_M_NONE;
    else
      target = BAD_M_DRAM;
  end
endmodule
`default_nettype wire

/* src/bad_top.sv */
// module: board address decoder top, registered selects and irq routing
`timescale 1ns/10ps
`default_nettype none
module bad_top
  import bad_pkg::*;
(
  input  wire logic        core_clk,     // 100 mhz bus clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic        cyc,          // cycle strobe
  input  wire logic        io_sel,       // 1 = io cycle, 0 = memory
  input  wire logic        wr,           // write cycle
  input  wire logic [31:0] addr,         // address lines
  input  wire logic [7:0]  wdata,        // low write data byte
  input  wire logic [1:0]  fit,          // dram fit code
  input  wire logic        real_md,      // real-mode map
  input  wire logic        vme_en,       // vme access enabled
  input  wire logic        mono,         // primary display mono
  input  wire logic        parity_err,   // parity error level
  input  wire logic        vme_evt,      // vme interface event
  input  wire logic        vme_irq,      // vme maskable request
  input  wire logic        nmi_en,       // nmi configuration enable
  input  wire logic        irq_alt,      // jumper: use line 12
  output bad_mem_t         mem_target,   // registered memory target
  output logic [23:0]      vme_off,      // registered window offset
  output bad_sel_t         io_target,    // registered port select
  output logic [7:0]       gate_reg,     // a20 gate / fast reset reg
  output logic             nmi,          // nmi to processor
  output logic [15:0]      irq           // maskable request lines
);
  logic [1:0] s_par, s_evt, s_irq; // pin synchronisers
  logic [1:0] s_nen, s_alt;
  bad_mem_t   m_t;     // memory decode
  logic [23:0] m_off;  // window offset
  bad_mem_t   next_mem;
  logic [23:0] next_off;
  bad_sel_t   next_io;
  logic [7:0] next_gate;
  logic       next_nmi;
  logic [15:0] next_irq;
  bad_dec_if  dif();

  assign dif.port = addr[15:0];
  assign dif.mono = mono;

  bad_port_dec u_port (.d(dif));
  bad_mem_dec u_mem (
    .addr    (addr),
    .fit     (bad_fit_t'(fit)),
    .real_md (real_md),
    .vme_en  (vme_en),
    .target  (m_t),
    .vme_off (m_off)
  );

  // next values: registered decode, gate register, interrupt routing
  always_comb
  begin
    next_mem  = BAD_M_NONE;
    next_off  = vme_off;
    next_io   = BAD_S_NONE;
    next_gate = gate_reg;
    if (cyc && !io_sel)
    begin
      next_mem = m_t;
      next_off = m_off;
    end
    if (cyc && io_sel)
      next_io = dif.sel; // any width accepted
    if (cyc && io_sel && wr && dif.sel == BAD_S_GATE)
      next_gate = wdata;
    next_nmi = s_nen[1] && (s_par[1] || s_evt[1]);
    next_irq = 16'h0000;
    if (s_alt[1])
      next_irq[12] = s_irq[1];
    else
      next_irq[11] = s_irq[1];
  end

  // registers only
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_par <= 2'b00;
      s_evt <= 2'b00;
      s_irq <= 2'b00;
      s_nen <= 2'b00;
      s_alt <= 2'b00;
      mem_target <= BAD_M_NONE;
      vme_off <= 24'h00_0000;
      io_target <= BAD_S_NONE;
      gate_reg <= BAD_GATE_RST;
      nmi <= 1'b0;
      irq <= 16'h0000;
    end
    else
    begin
      s_par <= {s_par[0], parity_err};
      s_evt <= {s_evt[0], vme_evt};
      s_irq <= {s_irq[0], vme_irq};
      s_nen <= {s_nen[0], nmi_en};
      s_alt <= {s_alt[0], irq_alt};
      mem_target <= next_mem;
      vme_off <= next_off;
      io_target <= next_io;
      gate_reg <= next_gate;
      nmi <= next_nmi;
      irq <= next_irq;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_rom;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && !io_sel && !real_md && addr >= BAD_ROM_BASE)
      |=> mem_target == BAD_M_ROM;
  endproperty
  a_rom: assert property (p_rom) else $error("rom miss");
  property p_rsvd;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && !io_sel && !real_md && addr[31:16] == 16'hFFFE)
      |=> mem_target == BAD_M_RSVD;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");
  property p_win1;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && !io_sel && !real_md && vme_en && fit == 2'd0
      && addr == BAD_WIN_1M) |=> mem_target == BAD_M_VME && vme_off == 0;
  endproperty
  a_win1: assert property (p_win1) else $error("window base");
  property p_alias;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && !io_sel && !real_md && vme_en && addr == BAD_ALIAS_TOP)
      |=> mem_target == BAD_M_VME;
  endproperty
  a_alias: assert property (p_alias) else $error("alias");
  property p_rmwin;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && !io_sel && real_md && addr[31:16] == 16'h000E)
      |=> mem_target == ($past(vme_en) ? BAD_M_VME : BAD_M_NONE);
  endproperty
  a_rmwin: assert property (p_rmwin) else $error("real win");
  property p_vme_io;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && io_sel && addr[15:4] == 12'h014) |=> io_target == BAD_S_VME;
  endproperty
  a_vme_io: assert property (p_vme_io) else $error("vme ports");
  property p_hi;
    @(posedge core_clk) disable iff (!rstn)
    (cyc && io_sel && addr[15:10] != 6'h00) |=> io_target == BAD_S_NONE;
  endproperty
  a_hi: assert property (p_hi) else $error("high port");
  property p_nmi;
    @(posedge core_clk) disable iff (!rstn)
    !nmi_en [*4] |-> !nmi;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi gate");
  property p_irq;
    @(posedge core_clk) disable iff (!rstn)
    irq[11] |-> !irq[12];
  endproperty
  a_irq: assert property (p_irq) else $error("irq line");
endmodule
`default_nettype wire

/* dv/bad_cpu_model.sv */
// partner: processor bus master issuing memory and io cycles
`timescale 1ns/10ps
`default_nettype none
module bad_cpu_model
(
  input  wire logic        core_clk, // bus clock
  output logic             cyc,      // cycle strobe
  output logic             io_sel,   // 1 io, 0 memory
  output logic             wr,       // write cycle
  output logic [31:0]      addr,     // address lines
  output logic [7:0]       wdata     // write byte
);
  // ************************************************************
  // bus cycle tasks
  // ************************************************************
  // idle bus at time zero
  initial
  begin
    {cyc, io_sel, wr, addr, wdata} = '0;
  end
  // present a cycle at the next edge and hold it there
  task automatic drive(input logic i, input logic [31:0] a,
                       input logic w, input logic [7:0] d);
    @(posedge core_clk);
    cyc    <= 1'h1;
    io_sel <= i;                           // io marked on select
    addr   <= i ? {16'h0000, a[15:0]} : a; // port on low lines
    wr     <= w;
    wdata  <= d;
  endtask
  // drop the strobe; lines invert so no stale value lingers
  task automatic release_bus();
    @(posedge core_clk);
    cyc    <= 1'h0;
    io_sel <= ~io_sel;
    addr   <= ~addr;
    wr     <= ~wr;
    wdata  <= ~wdata;
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// testbench: directed and random cycles through the address decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import bad_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic        core_clk     = 1'h0;  // 100 mhz clock
  logic        rstn         = 1'h0;  // reset, active low
  logic        cyc;                  // cpu model strobe
  logic        io_sel;               // cpu model select
  logic        wr;                   // cpu model write
  logic [31:0] addr;                 // cpu model address
  logic [7:0]  wdata;                // cpu model data
  logic [1:0]  fit          = 2'h0;  // dram fit code
  logic        real_md      = 1'h0;  // 20-bit map
  logic        vme_en       = 1'h0;  // vme enabled
  logic        mono         = 1'h0;  // mono display
  logic [4:0]  pins         = 5'h00; // nmi_en,parity,evt,irq,alt
  bad_mem_t    mem_target;           // memory target
  logic [23:0] vme_off;              // window offset
  bad_sel_t    io_target;            // port select
  logic [7:0]  gate_reg;             // gate register
  logic        nmi;                  // nmi out
  logic [15:0] irq;                  // request lines
  logic [7:0]  exp_gate     = 8'h00; // expected gate value
  int          n_mismatch   = 0;     // mismatches
  int          total_checks = 0;     // comparisons
  int          cycles       = 0;     // hang guard
  int          seed         = 53985; // fixed seed
  logic [31:0] r;                    // random word
  logic [31:0] a;                    // random address
  logic [31:0] b;                    // window base
  // ************************************************************
  // design and bus master
  // ************************************************************
  bad_top u_dut (
    .core_clk(core_clk), .rstn(rstn), .cyc(cyc), .io_sel(io_sel),
    .wr(wr), .addr(addr), .wdata(wdata), .fit(fit), .real_md(real_md),
    .vme_en(vme_en), .mono(mono), .parity_err(pins[3]),
    .vme_evt(pins[2]), .vme_irq(pins[1]), .nmi_en(pins[4]),
    .irq_alt(pins[0]), .mem_target(mem_target), .vme_off(vme_off),
    .io_target(io_target), .gate_reg(gate_reg), .nmi(nmi), .irq(irq));
  bad_cpu_model u_cpu (.core_clk(core_clk), .cyc(cyc), .io_sel(io_sel),
    .wr(wr), .addr(addr), .wdata(wdata));
  // clock, and a cycle ceiling well above the run length
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ************************************************************
  // expectations
  // ************************************************************
  function automatic logic [31:0] win_base(input logic [1:0] f);
    return (f == 2'h1) ? BAD_WIN_4M : (f == 2'h2) ? BAD_WIN_16M : BAD_WIN_1M;
  endfunction
  function automatic bad_mem_t exp_mem(input logic [31:0] x);
    if (real_md)
    begin
      if (x > 32'h000F_FFFF) return BAD_M_NONE;
      if (x >= 32'h000F_0000) return BAD_M_ROM;
      if (x >= 32'h000E_0000) return vme_en ? BAD_M_VME : BAD_M_NONE;
      return BAD_M_DRAM;
    end
    if (x >= 32'hFFFF_0000) return BAD_M_ROM;
    if (x >= 32'hFFFE_0000) return BAD_M_RSVD;
    if (x >= win_base(fit)) return vme_en ? BAD_M_VME : BAD_M_NONE;
    return BAD_M_DRAM;
  endfunction
  function automatic bad_sel_t exp_io(input logic [15:0] p);
    if (p[15:10] != 6'h00) return BAD_S_NONE;
    case (p[9:0]) inside
      [10'h000:10'h00F]: return BAD_S_DMA1;
      [10'h020:10'h021]: return BAD_S_PIC1;
      [10'h040:10'h043]: return BAD_S_PIT;
      [10'h060:10'h064]: return BAD_S_KBD;
      [10'h070:10'h071]: return BAD_S_RTC;
      [10'h080:10'h08F]: return BAD_S_PAGE;
      10'h092:           return BAD_S_GATE;
      [10'h0A0:10'h0A1]: return BAD_S_PIC2;
      [10'h0C0:10'h0DF]: return BAD_S_DMA2;
      [10'h0F0:10'h0FF]: return BAD_S_FPU;
      [10'h140:10'h14F]: return BAD_S_VME;
      [10'h170:10'h177]: return BAD_S_HD2;
      [10'h1F0:10'h1F7]: return BAD_S_HD1;
      [10'h2F8:10'h2FE]: return BAD_S_SER2;
      [10'h3B0:10'h3BF]: return mono ? BAD_S_VID : BAD_S_NONE;
      [10'h3D0:10'h3DF]: return mono ? BAD_S_NONE : BAD_S_VID;
      [10'h3F0:10'h3F7]: return BAD_S_FDC;
      [10'h3F8:10'h3FE]: return BAD_S_SER1;
      default:           return BAD_S_NONE;
    endcase
  endfunction
  // ************************************************************
  // compare and cycle tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // outputs one edge after the cycle was taken
  task automatic check_out(input logic i, input logic [31:0] x,
                           input logic w, input logic [7:0] d);
    bad_mem_t em;
    bad_sel_t es;
    em = i ? BAD_M_NONE : exp_mem(x);
    es = i ? exp_io(x[15:0]) : BAD_S_NONE;
    if (i && w && x[15:0] == 16'h0092) exp_gate = d;
    chk("mem_target", em, mem_target);
    chk("io_target", es, io_target);
    chk("gate_reg", exp_gate, gate_reg);
    if (em == BAD_M_VME && !real_md)
      chk("vme_off", x - win_base(fit) & 32'h00FF_FFFF, vme_off);
    // real-mode window offset is the low sixteen lines
    else if (em == BAD_M_VME)
      chk("vme_off_rm", {16'h0000, x[15:0]}, vme_off);
  endtask
  task automatic one(input logic i, input logic [31:0] x, input logic w,
                     input logic [7:0] d);
    u_cpu.drive(i, x, w, d);
    u_cpu.release_bus();
    #1;
    check_out(i, x, w, d);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    chk("reset", 32'h0000_0000, {gate_reg, nmi, irq});
    chk("reset_sel", 32'h0, {mem_target, io_target, vme_off});
    @(posedge core_clk);
    rstn <= 1'h1;
    // every port of the ten-line space, in both display settings
    for (int m = 0; m < 2; m++)
    begin
      @(posedge core_clk);
      mono <= m[0];
      for (int p = 0; p < 1024; p++)
        one(1'h1, p, 1'h0, 8'h00);
      one(1'h1, 32'h0000_4140, 1'h0, 8'h00);
      one(1'h1, 32'h0000_01F7, 1'h0, 8'h00);
      one(1'h1, 32'h0000_03FE, 1'h0, 8'h00);
    end
    // window edges for every fit, with and without vme access
    for (int k = 0; k < 6; k++)
    begin
      @(posedge core_clk);
      {fit, vme_en} <= k[2:0];
      b = win_base(k[2:1]);
      one(1'h0, b, 1'h0, 8'h00);
      foreach (b[j])
        if (j < 9)
          one(1'h0, j < 4 ? b + (32'h0080_0000 * j) - 32'h1 : 32'hFFFD_FFFF
              + 32'h0000_8000 * (j - 4), 1'h0, 8'h00);
    end
    // real-mode map edges
    real_md <= 1'h1;
    for (int k = 0; k < 18; k++)
      one(1'h0, 32'h000C_0000 + 32'h0001_0000 * (k / 2) - k[0],
          1'h0, 8'h00);
    real_md <= 1'h0;
    // gate register writes: hit, neighbour, refused alias
    one(1'h1, 32'h0000_0092, 1'h1, 8'h5A);
    one(1'h1, 32'h0000_0093, 1'h1, 8'hC3);
    one(1'h1, 32'h0000_8092, 1'h1, 8'h3C);
    // back to back, then the select must drop
    u_cpu.drive(1'h1, 32'h0000_0140, 1'h0, 8'h00);
    u_cpu.drive(1'h0, 32'hFFFF_0000, 1'h0, 8'h00);
    #1;
    check_out(1'h1, 32'h0000_0140, 1'h0, 8'h00);
    u_cpu.release_bus();
    #1;
    check_out(1'h0, 32'hFFFF_0000, 1'h0, 8'h00);
    @(posedge core_clk);
    #1;
    chk("idle", {BAD_M_NONE, BAD_S_NONE}, {mem_target, io_target});
    // random cycles with random configuration
    repeat (400)
    begin
      r = $random(seed);
      a = $random(seed);
      @(posedge core_clk);
      {fit, vme_en, mono, real_md} <= r[4:0];
      if (r[5])
        a = r[9] ? 32'h0000_0092 : r[7] ? a : a & 32'h0000_03FF;
      else
        a = r[0] ? a & 32'h000F_FFFF : a | 32'h0010_0000;
      one(r[5], a, r[8], r[15:8]);
    end
    // nmi gating and request line choice
    for (int k = 0; k < 32; k++)
    begin
      @(posedge core_clk);
      pins <= k[4:0];
      repeat (4) @(posedge core_clk);
      #1;
      chk("nmi", k[4] & (k[3] | k[2]), nmi);
      chk("irq", k[1] ? 16'h0800 << k[0] : 16'h0000, irq);
    end
    // reset in mid-run clears the gate register
    @(posedge core_clk);
    rstn <= 1'h0;
    @(posedge core_clk);
    rstn <= 1'h1;
    exp_gate = 8'h00;
    one(1'h1, 32'h0000_0092, 1'h0, 8'hFF);
    give_verdict();
  end
endmodule
`default_nettype wire
